/* pkg/pgs_defines.vh */
// Purpose: constants for the priority split and reset control block
// Assumes: 32-bit classic wishbone, word-aligned byte offsets
// Notes:   offsets are byte addresses
`ifndef PGS_DEFINES_VH
`define PGS_DEFINES_VH
`define PGS_ADDR_W          4
`define PGS_OFF_CTRL        4'h0
`define PGS_OFF_SPLIT       4'h4
`define PGS_OFF_CMP         4'h8
`define PGS_OFF_STAT        4'hC
`define PGS_BIT_DBGCLR      1
`define PGS_BIT_RSTREQ      2
`define PGS_BIT_SECONLY     3
`define PGS_SPLIT_LSB       8
`define PGS_SPLIT_MSB       10
`define PGS_SPLIT_RST       3'h0
`define PGS_SPLIT_ALLSUB    3'h7
`define PGS_PRI_W           8
`define PGS_CNT_W           9
`endif

/* test/pgs_top_chk.sv */
// Purpose: concurrent checks on pgs_top ports
// Assumes: one clock, sync active high reset
// Notes:   lane enables are always full in the bench
`timescale 1ns/10ps
module pgs_top_chk (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [3:0]  wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire        wb_nonsecure_i,
    input wire        wb_ack_o,
    input wire        preempt_o,
    input wire        pend_first_o,
    input wire [7:0]  pend_group_o,
    input wire [7:0]  pend_sub_o,
    input wire [2:0]  priority_split_select_o,
    input wire        system_reset_request_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire ctl  = take && wb_we_i && wb_adr_i == 4'h0;
    wire [2:0] sel = priority_split_select_o;
    chk_ack_next: assert property (take |=> wb_ack_o)
        else $error("no ack after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_rst_set: assert property (ctl && !wb_nonsecure_i && wb_dat_i[2]
        |=> system_reset_request_o) else $error("reset request not set");
    chk_rst_clr: assert property (ctl && !wb_nonsecure_i && !wb_dat_i[2]
        |=> !system_reset_request_o) else $error("reset request stuck");
    chk_rst_hold: assert property (!ctl |=> $stable(system_reset_request_o))
        else $error("reset request moved without write");
    chk_split_load: assert property (take && wb_we_i && wb_adr_i == 4'h4
        |=> sel == $past(wb_dat_i[10:8])) else $error("split not loaded");
    chk_split_none: assert property (sel == 3'h7 && $past(sel) == 3'h7
        |-> pend_group_o == 8'h00) else $error("group bits at split 7");
    chk_split_mask: assert property ($stable(sel) |-> (pend_group_o &
        pend_sub_o) == 8'h00 && (pend_sub_o >> sel) <= 8'h01)
        else $error("split fields overlap");
    chk_first_grp: assert property (preempt_o |-> pend_first_o)
        else $error("preempt without first");
    cover property (wb_ack_o && !wb_we_i);
    cover property (preempt_o);
    cover property ($rose(system_reset_request_o));
endmodule // pgs_top_chk
bind pgs_top pgs_top_chk pgs_top_chk_inst (.*);

/* test/testbench.sv */
// Purpose: bus and priority split checks for pgs_top
// Assumes: ack one cycle after request, registered outputs
// Notes:   read data is matched in order from a queue
`timescale 1ns/10ps
module testbench;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg         wb_cyc_i = 1'b0;
    reg         wb_stb_i = 1'b0;
    reg         wb_we_i = 1'b0;
    reg  [3:0]  wb_adr_i = 4'h0;
    reg  [3:0]  wb_sel_i = 4'hF;
    reg  [31:0] wb_dat_i = 32'h0;
    reg         wb_nonsecure_i = 1'b0;
    reg  [7:0]  pend_level_i = 8'h0;
    reg  [7:0]  act_level_i = 8'h0;
    wire        wb_ack_o, preempt_o, pend_first_o, system_reset_request_o;
    wire        debug_clear_active_o;
    wire [31:0] wb_dat_o;
    wire [7:0]  pend_group_o, pend_sub_o;
    wire [2:0]  priority_split_select_o;
    integer     mismatches = 0, n_tests = 0, seed = 76;
    logic [31:0] q[$];
    pgs_top pgs_top_inst (.*);
    always #2 clk_i = ~clk_i;
    task final_report;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // debug clear bit is always written zero: its effect is undefined
    task wb(input ns, input w, input [3:0] a, input [31:0] d, input [31:0] e);
        integer k;
        @(posedge clk_i);
        if (!w) q.push_back(e);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
        {wb_nonsecure_i, wb_adr_i, wb_dat_i} <= {ns, a, d};
        // ack is sampled on the rising edge only; release at that edge
        for (k = 0; k < 50 && wb_ack_o !== 1'b1; k++)
            @(posedge clk_i);
        if (k == 50) begin
            mismatches++;
            final_report;
        end
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(negedge clk_i);
    endtask
    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && !wb_we_i && q.size() > 0)
            chk(wb_dat_o, q.pop_front());
    initial begin
        logic [7:0] p, a, m;
        logic [15:0] w;
        integer s, j;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 0, 4'h0, 0, 32'h0);
        wb(0, 1, 4'h0, 32'h4, 0);
        chk(system_reset_request_o, 1);
        chk(debug_clear_active_o, 0);
        wb(0, 1, 4'h0, 32'hC, 0);
        wb(1, 1, 4'h0, 32'h0, 0);
        chk(system_reset_request_o, 1);
        wb(1, 0, 4'h0, 0, 32'h0);
        wb(0, 0, 4'h0, 0, 32'hC);
        wb(0, 1, 4'h0, 32'h0, 0);
        chk(system_reset_request_o, 0);
        wb(0, 0, 4'h2, 0, 32'h0);
        for (s = 0; s < 8; s++) begin
            wb(0, 1, 4'h4, s << 8, 0);
            wb(0, 0, 4'hC, 0, {6'h0, 1'b1, 9'h002 << s, 7'h0,
                9'h100 >> (s + 1)});
            w = 16'h01FE << s;
            m = w[7:0];
            for (j = 0; j < 4; j++) begin
                p = 8'($random(seed));
                a = j[0] ? p ^ 8'h01 : 8'($random(seed));
                @(posedge clk_i);
                {pend_level_i, act_level_i} <= {p, a};
                wb(0, 1, 4'h8, {16'h0, a, p}, 0);
                chk(pend_group_o, p & m);
                chk(pend_sub_o, p & ~m);
                chk(preempt_o, (p & m) < (a & m));
                chk(pend_first_o, p < a);
            end
        end
        final_report;
    end
endmodule // testbench

/* verilog/pgs_preempt.v */
// Purpose: decide pre-emption and order between two priority levels
// Assumes: lower numeric value means higher urgency
// Notes:   subpriority only breaks ties once group is equal
`timescale 1ns/10ps
`include "pgs_defines.vh"
module pgs_preempt (
    // selector and the two levels
    input  wire [2:0] sel_i,
    input  wire [7:0] pend_i,
    input  wire [7:0] act_i,
    // decisions
    output wire       preempt_o,
    output wire       pend_first_o
);
    wire [7:0] pend_grp;
    wire [7:0] pend_sub;
    wire [7:0] act_grp;
    wire [7:0] act_sub;
    pgs_split u_pend (
        .sel_i   (sel_i),
        .level_i (pend_i),
        .group_o (pend_grp),
        .sub_o   (pend_sub)
    );
    pgs_split u_act (
        .sel_i   (sel_i),
        .level_i (act_i),
        .group_o (act_grp),
        .sub_o   (act_sub)
    );
    // only group fields decide pre-emption
    assign preempt_o    = (pend_grp < act_grp);
    // equal group: smaller subpriority goes first
    assign pend_first_o = (pend_grp < act_grp) ||
                          ((pend_grp == act_grp) &&
                           (pend_sub < act_sub));
endmodule // pgs_preempt

/* verilog/pgs_split.v */
// Purpose: split one priority level into group and subpriority parts
// Assumes: selector value 7 means no group bits
// Notes:   group part is left aligned, low bits zeroed
`timescale 1ns/10ps
`include "pgs_defines.vh"
module pgs_split (
    // selector and level
    input  wire [2:0] sel_i,
    input  wire [7:0] level_i,
    // fields
    output wire [7:0] group_o,
    output wire [7:0] sub_o
);
    wire [7:0] sub_mask;
    // mask covers bits sel down to 0; sel 7 covers all
    assign sub_mask = (8'hFF >> (3'h7 - sel_i));
    assign group_o  = level_i & ~sub_mask;
    assign sub_o    = level_i & sub_mask;
endmodule // pgs_split

/* verilog/pgs_top.v */
// Summary of operation
// - control bit 2 writes request system reset
// - secure-only set: non-secure reset bit RAZ/WI
// - selector places binary point in level
// - selector n: group [7:n+1], sub [n:0]
// - selector 7: all eight bits subpriority
// - group count 128 halving, sub count doubling
// - pre-emption compares group fields only
//
// Purpose: priority split selector and reset request control
// Assumes: classic wishbone slave, one clock, sync reset
// Notes:   ack one cycle after stb; unmapped reads zero, writes drop
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`include "pgs_defines.vh"
module pgs_top (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    input  wire        wb_nonsecure_i,
    output wire        wb_ack_o,
    output reg  [31:0] wb_dat_o,
    // priority levels to compare
    input  wire [7:0]  pend_level_i,
    input  wire [7:0]  act_level_i,
    // decisions and state
    output reg         preempt_o,
    output reg         pend_first_o,
    output reg  [7:0]  pend_group_o,
    output reg  [7:0]  pend_sub_o,
    output wire [2:0]  priority_split_select_o,
    output wire        system_reset_request_o,
    output reg         debug_clear_active_o
);
    reg        ack_r;
    reg [2:0]  split_r;
    reg        seconly_r;
    reg        rstreq_r;
    reg [7:0]  cmp_pend_r;
    reg [7:0]  cmp_act_r;
    wire       req;
    wire       wr;
    wire       preempt_w;
    wire       first_w;
    wire [7:0] grp_w;
    wire [7:0] sub_w;
    wire       sec_ok;

    // number of group levels: 2^(7-sel); subs 2^(sel+1)
    function [8:0] grp_count;
        input [2:0] s;
        begin
            grp_count = 9'h080 >> s;
        end
    endfunction
    function [8:0] sub_count;
        input [2:0] s;
        begin
            sub_count = 9'h002 << s;
        end
    endfunction

    assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr       = req & wb_we_i;
    assign wb_ack_o = ack_r;
    // non-secure access to reset bit blocked when secure-only
    assign sec_ok   = ~(wb_nonsecure_i & seconly_r);
    assign priority_split_select_o = split_r;
    assign system_reset_request_o  = rstreq_r;

    pgs_preempt u_cmp (
        .sel_i        (split_r),
        .pend_i       (pend_level_i),
        .act_i        (act_level_i),
        .preempt_o    (preempt_w),
        .pend_first_o (first_w)
    );
    pgs_split u_view (
        .sel_i   (split_r),
        .level_i (cmp_pend_r),
        .group_o (grp_w),
        .sub_o   (sub_w)
    );

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r                <= 1'b0;
            split_r              <= `PGS_SPLIT_RST;
            seconly_r            <= 1'b0;
            rstreq_r             <= 1'b0;
            debug_clear_active_o <= 1'b0;
            cmp_pend_r           <= 8'h00;
            cmp_act_r            <= 8'h00;
            preempt_o            <= 1'b0;
            pend_first_o         <= 1'b0;
            pend_group_o         <= 8'h00;
            pend_sub_o           <= 8'h00;
        end else begin
            ack_r                <= req;
            preempt_o            <= preempt_w;
            pend_first_o         <= first_w;
            pend_group_o         <= grp_w;
            pend_sub_o           <= sub_w;
            // debug clear is a one-cycle strobe, never stored
            debug_clear_active_o <= 1'b0;
            if (wr && wb_adr_i == `PGS_OFF_CTRL && wb_sel_i[0]) begin
                // a one here is unpredictable; we just pulse it
                debug_clear_active_o <= wb_dat_i[`PGS_BIT_DBGCLR];
                if (sec_ok)
                    rstreq_r <= wb_dat_i[`PGS_BIT_RSTREQ];
                if (!wb_nonsecure_i)
                    seconly_r <= wb_dat_i[`PGS_BIT_SECONLY];
            end
            if (wr && wb_adr_i == `PGS_OFF_SPLIT && wb_sel_i[1])
                split_r <= wb_dat_i[`PGS_SPLIT_MSB:`PGS_SPLIT_LSB];
            if (wr && wb_adr_i == `PGS_OFF_CMP) begin
                if (wb_sel_i[0])
                    cmp_pend_r <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    cmp_act_r <= wb_dat_i[15:8];
            end
        end
    end
    always @(posedge clk_i) begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (req && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i)
                `PGS_OFF_CTRL: begin
                    wb_dat_o[`PGS_BIT_RSTREQ]  <= rstreq_r & sec_ok;
                    wb_dat_o[`PGS_BIT_SECONLY] <= seconly_r & ~wb_nonsecure_i;
                end
                `PGS_OFF_SPLIT:
                    wb_dat_o[`PGS_SPLIT_MSB:`PGS_SPLIT_LSB] <= split_r;
                `PGS_OFF_CMP:
                    wb_dat_o[15:0] <= {cmp_act_r, cmp_pend_r};
                `PGS_OFF_STAT: begin
                    wb_dat_o[8:0]   <= grp_count(split_r);
                    wb_dat_o[24:16] <= sub_count(split_r);
                    wb_dat_o[25]    <= (cmp_pend_r & ~grp_w) == sub_w;
                end
                default:
                    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule // pgs_top
